// [hw/cmft_pkg.sv]
package cmft_pkg;
  localparam int          NSLOT        = 6;
  localparam int          NBYTE        = 8;
  // Register byte offsets
  localparam logic [7:0]  OFS_GCON     = 8'h00;
  localparam logic [7:0]  OFS_GSTA     = 8'h04;
  localparam logic [7:0]  OFS_GIT      = 8'h08;
  localparam logic [7:0]  OFS_IE       = 8'h0c;
  localparam logic [7:0]  OFS_SIT      = 8'h10;
  localparam logic [7:0]  OFS_PAGE     = 8'h14;
  localparam logic [7:0]  OFS_HPRI     = 8'h18;
  localparam logic [7:0]  OFS_TCON     = 8'h1c;
  localparam logic [7:0]  OFS_TIMER    = 8'h20;
  localparam logic [7:0]  OFS_ECNT     = 8'h24;
  localparam logic [7:0]  OFS_SCFG     = 8'h28;
  localparam logic [7:0]  OFS_SIDT     = 8'h2c;
  localparam logic [7:0]  OFS_SMSK     = 8'h30;
  localparam logic [7:0]  OFS_SSTA     = 8'h34;
  localparam logic [7:0]  OFS_SMSG     = 8'h38;
  localparam logic [7:0]  OFS_SSTMP    = 8'h3c;
  localparam logic [7:0]  OFS_SYNC     = 8'h40;
  // Reset values
  localparam logic [7:0]  TCON_RST     = 8'h00;
  localparam logic [15:0] TIMER_RST    = 16'h0000;
  localparam logic [15:0] TIMER_MAX    = 16'hffff;
  localparam logic [3:0]  HPRI_NONE    = 4'hf;
  // Timing counts
  localparam logic [2:0]  DIV_LAST     = 3'h7;
  localparam logic [2:0]  STUFF_LIMIT  = 3'h5;
  localparam logic [3:0]  SUSPEND_BITS = 4'h8;
  localparam logic [14:0] CRC_POLY     = 15'h4599;
  // Fault confinement thresholds
  localparam logic [8:0]  PASSIVE_LIM  = 9'h07f;
  localparam logic [8:0]  BUSOFF_LIM   = 9'h0ff;
  localparam logic [8:0]  TEC_STEP     = 9'h008;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TX  = 2'b01,
    MODE_RX  = 2'b10,
    MODE_FB  = 2'b11
  } cmft_mode_e;

  // One sampled bit from the bit engine
  typedef struct packed {
    logic strobe;
    logic rx;
    logic tx;
    logic sending;
    logic arb;
    logic ack_slot;
    logic err_frame;
    logic fixed_form;
    logic crc_cover;
    logic crc_field;
    logic crc_end;
    logic stuffed;
  } cmft_bit_s;

  // Frame level events from the frame engine
  typedef struct packed {
    logic        sof;
    logic        eof;
    logic        id_strobe;
    logic [28:0] id;
    logic        ide;
    logic        rtr;
    logic [1:0]  rb;
    logic [3:0]  dlc;
    logic        byte_strobe;
    logic [7:0]  data;
    logic        rx_done;
    logic        tx_done;
    logic [2:0]  tx_slot;
    logic        foreign_err;
  } cmft_frame_s;

  typedef struct packed {
    cmft_mode_e  mode;
    logic        reply_valid_bit;
    logic        ide;
    logic        rtr;
    logic [1:0]  rb;
    logic [3:0]  dlc;
    logic [28:0] id;
    logic [28:0] identifier_mask;
    logic        ide_m;
    logic        rtr_m;
    logic [6:0]  sta;
    logic [15:0] stamp;
  } cmft_slot_s;
endpackage : cmft_pkg

// [hw/cmft_core.sv]
`timescale 1ns/10ps
// How it works
// - Two-bit mode field per slot, reset disabled
// - Six slots, lowest number wins ties
// - Slot receives only after mode set
// - Search receive slots, pick lowest-numbered match
// - Hit overwrites tag, extension, length
// - Completion stores bytes, sets receive flag
// - Matched remote with reply clears, replies
// - Buffer-complete after whole set received
// - Buffer-complete clear needs all rewritten
// - Masked compare of identifier, remote, extension
// - Page register picks visible slot
// - Top priority slot from enabled sources
// - Per-slot byte buffer behind index
// - Index auto-advances, wraps seven to zero
// - Tick every eight times prescale plus one
// - Timer starts zero, wrap sets overrun
// - Sync edge select, single-shot sending
// - Done flags capture time stamp
// - Error counters, passive and bus-off states
// - Passive waits after sending, bus-off silent
// - Bit error with arbitration exceptions
// - Stuff error on sixth equal bit
// - CRC check over covered frame bits
// - Form error and missing acknowledge
// - Errors to slot or general flags
// - Error frame on own or foreign error
module cmft_core import cmft_pkg::*; #(
  parameter int NS = NSLOT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire cmft_bit_s   bt,
  input  wire cmft_frame_s fr,
  output logic             err_frame_req,
  output logic             err_passive,
  output logic             drive_en,
  output logic             tx_hold,
  output logic             single_shot,
  output logic             reply_req,
  output logic [2:0]       reply_slot
);
  // ****************************************************
  // Bus slave
  // ****************************************************
  cmft_slot_s sl [NS];
  logic [2:0]  gcon;
  logic        swres;
  logic [2:0]  ie;
  logic [7:0]  tcon;
  logic [2:0]  page;
  logic        auto_increment_disable_dis;
  logic [2:0]  idx;
  logic [7:0]  git;
  logic [7:0]  dbuf [NS][NBYTE];
  logic [15:0] timer;
  logic [15:0] sync_stamp;
  logic        controller_enabled_flag;
  logic [8:0]  tec;
  logic [7:0]  rec;
  logic        bus_off_status;
  logic [3:0]  hpri;
  logic [NS-1:0] sit;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        acc;
  logic        rd_msg;
  logic        we;
  logic        pg_ok;
  logic        wr_msg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc    = hsel & hready & htrans[1];
  assign we     = wr_pend & ce;
  assign pg_ok  = (page < 3'(NS));
  assign rd_msg = ce & acc & !hwrite & (haddr[7:0] == OFS_SMSG) & pg_ok;
  assign wr_msg = we & (wr_addr == OFS_SMSG) & pg_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pend <= acc & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    cmft_slot_s s;
    s = sl[pg_ok ? page : 3'h0];
    case (a)
      OFS_GCON:  rd_mux = {29'h0, gcon};
      OFS_GSTA:  rd_mux = {29'h0, controller_enabled_flag, bus_off_status, err_passive};
      OFS_GIT:   rd_mux = {24'h0, git};
      OFS_IE:    rd_mux = {29'h0, ie};
      OFS_SIT:   rd_mux = 32'(sit);
      OFS_PAGE:  rd_mux = {25'h0, idx, auto_increment_disable_dis, page};
      OFS_HPRI:  rd_mux = {28'h0, hpri};
      OFS_TCON:  rd_mux = {24'h0, tcon};
      OFS_TIMER: rd_mux = {16'h0, timer};
      OFS_ECNT:  rd_mux = {7'h0, tec, 8'h00, rec};
      OFS_SYNC:  rd_mux = {16'h0, sync_stamp};
      default:   rd_mux = 32'h0;
    endcase
    if (pg_ok) begin
      case (a)
        OFS_SCFG:  rd_mux = {20'h0, s.dlc, 1'b0, s.rb, s.rtr, s.ide, s.reply_valid_bit,
                             s.mode};
        OFS_SIDT:  rd_mux = {3'h0, s.id};
        OFS_SMSK:  rd_mux = {1'b0, s.rtr_m, s.ide_m, s.identifier_mask};
        OFS_SSTA:  rd_mux = {25'h0, s.sta};
        OFS_SMSG:  rd_mux = {24'h0, dbuf[page][idx]};
        OFS_SSTMP: rd_mux = {16'h0, s.stamp};
        default:   rd_mux = rd_mux;
      endcase
    end
  endfunction : rd_mux

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (ce && acc && !hwrite) begin
      hrdata <= rd_mux(haddr[7:0]);
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gcon     <= 3'h0;
      swres    <= 1'b0;
      ie       <= 3'h0;
      tcon     <= TCON_RST;
      page     <= 3'h0;
      auto_increment_disable_dis <= 1'b0;
      idx      <= 3'h0;
    end else if (ce) begin
      swres <= we & (wr_addr == OFS_GCON) & hwdata[3];
      if (we && wr_addr == OFS_GCON) gcon <= hwdata[2:0];
      if (we && wr_addr == OFS_IE) ie <= hwdata[2:0];
      if (we && wr_addr == OFS_TCON) tcon <= hwdata[7:0];
      if (we && wr_addr == OFS_PAGE) begin
        page     <= hwdata[2:0];
        auto_increment_disable_dis <= hwdata[3];
        idx      <= hwdata[6:4];
      end else if ((rd_msg || wr_msg) && !auto_increment_disable_dis) begin
        idx <= idx + 3'h1;
      end
    end
  end
  assign single_shot = gcon[1];

  // ****************************************************
  // Acceptance filter
  // ****************************************************
  logic       hit_any;
  logic [2:0] hit_idx;
  logic       cur_valid;
  logic [2:0] cur_slot;
  logic       cur_rtr;
  logic [63:0] shadow;
  logic [2:0]  bcnt;

  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    // descending scan leaves the lowest match
    for (int s = NS - 1; s >= 0; s--) begin
      if (sl[s].mode[1] &&
          (((fr.id ^ sl[s].id) & sl[s].identifier_mask) == 29'h0) &&
          (!sl[s].rtr_m || fr.rtr == sl[s].rtr) &&
          (!sl[s].ide_m || fr.ide == sl[s].ide) &&
          fr.rb == sl[s].rb) begin
        hit_any = 1'b1;
        hit_idx = 3'(s);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_valid <= 1'b0;
      cur_slot  <= 3'h0;
      cur_rtr   <= 1'b0;
      shadow    <= 64'h0;
      bcnt      <= 3'h0;
    end else if (ce) begin
      if (swres || fr.sof || fr.rx_done) cur_valid <= 1'b0;
      if (fr.id_strobe && controller_enabled_flag) begin
        cur_valid <= hit_any & !(fr.rtr & sl[hit_idx].reply_valid_bit);
        cur_slot  <= hit_idx;
        cur_rtr   <= fr.rtr;
      end
      // frame byte n lands at index n
      if (fr.byte_strobe) begin
        shadow[8*bcnt +: 8] <= fr.data;
        bcnt                <= bcnt + 3'h1;
      end
      if (fr.sof) begin
        shadow <= 64'h0;
        bcnt   <= 3'h0;
      end
    end
  end

  // ****************************************************
  // Mailbox slots
  // ****************************************************
  logic [NS-1:0] fb_set;
  logic [NS-1:0] fb_done;
  logic [NS-1:0] rewr;
  logic [6:0]    slot_err;
  logic [4:0]    err_v;
  logic          bx_hit;
  logic          bx_hit_q;
  logic          bx_rise;

  always_comb begin
    for (int s = 0; s < NS; s++) fb_set[s] = (sl[s].mode == MODE_FB);
  end
  assign bx_hit  = (|fb_set) && ((fb_set & ~fb_done) == '0);
  assign bx_rise = bx_hit & !bx_hit_q;
  assign slot_err = {err_v[0], err_v[1], err_v[2], err_v[3], err_v[4], 2'b00};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NS; s++) begin
        sl[s] <= '0;
        for (int b = 0; b < NBYTE; b++) dbuf[s][b] <= 8'h00;
      end
      fb_done   <= '0;
      rewr      <= '0;
      bx_hit_q  <= 1'b0;
      reply_req <= 1'b0;
      reply_slot <= 3'h0;
    end else if (ce) begin
      bx_hit_q  <= bx_hit;
      reply_req <= 1'b0;
      if (bx_rise) rewr <= '0;
      for (int s = 0; s < NS; s++) begin
        if (swres) begin
          sl[s].sta <= 7'h0;
          fb_done[s] <= 1'b0;
        end
        if (we && pg_ok && page == 3'(s)) begin
          case (wr_addr)
            OFS_SCFG: begin
              sl[s].mode <= cmft_mode_e'(hwdata[1:0]);
              sl[s].reply_valid_bit <= hwdata[2];
              sl[s].ide  <= hwdata[3];
              sl[s].rtr  <= hwdata[4];
              sl[s].rb   <= hwdata[6:5];
              sl[s].dlc  <= hwdata[11:8];
              fb_done[s] <= 1'b0;
              rewr[s]    <= 1'b1;
            end
            OFS_SIDT: sl[s].id <= hwdata[28:0];
            OFS_SMSK: begin
              sl[s].identifier_mask <= hwdata[28:0];
              sl[s].ide_m <= hwdata[29];
              sl[s].rtr_m <= hwdata[30];
            end
            OFS_SSTA: sl[s].sta <= sl[s].sta & hwdata[6:0];
            default: ;
          endcase
        end
        // slot buffer written through the index
        if (wr_msg && page == 3'(s)) dbuf[s][idx] <= hwdata[7:0];
        if (fr.id_strobe && controller_enabled_flag && hit_any && hit_idx == 3'(s)) begin
          sl[s].id  <= fr.id;
          sl[s].ide <= fr.ide;
          sl[s].dlc <= fr.dlc;
          sl[s].rb  <= fr.rb;
          sl[s].rtr <= fr.rtr;
          // remote hit on reply slot turns it round
          if (fr.rtr && sl[s].reply_valid_bit) begin
            sl[s].rtr  <= 1'b0;
            sl[s].reply_valid_bit <= 1'b0;
            sl[s].mode <= MODE_TX;
            reply_req  <= 1'b1;
            reply_slot <= 3'(s);
          end
        end
        if (fr.rx_done && cur_valid && cur_slot == 3'(s)) begin
          if (!cur_rtr) begin
            for (int b = 0; b < NBYTE; b++) dbuf[s][b] <= shadow[8*b +: 8];
          end
          sl[s].sta[0] <= 1'b1;
          sl[s].stamp  <= timer;
          if (sl[s].mode == MODE_FB) fb_done[s] <= 1'b1;
        end
        if (fr.tx_done && fr.tx_slot == 3'(s)) begin
          sl[s].sta[1] <= 1'b1;
          sl[s].stamp  <= timer;
        end
        // slot errors while sending or matched
        if ((|slot_err) && ((bt.sending && fr.tx_slot == 3'(s)) ||
            (!bt.sending && cur_valid && cur_slot == 3'(s)))) begin
          sl[s].sta[6:2] <= sl[s].sta[6:2] | slot_err[6:2];
        end
      end
    end
  end

  // ****************************************************
  // General flags and top priority slot
  // ****************************************************
  logic       gen_err;
  logic       ovr_evt;
  logic       bus_off_status_evt;
  logic [NS-1:0] bx_snap;
  logic       bx_clr_ok;

  assign gen_err   = !bt.sending && !cur_valid;
  // every slot of the set must be rewritten first
  assign bx_clr_ok = ((bx_snap & ~rewr) == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      git     <= 8'h00;
      bx_snap <= '0;
    end else if (ce) begin
      if (swres) begin
        git <= 8'h00;
      end else if (we && wr_addr == OFS_GIT) begin
        git[6:5] <= git[6:5] & ~hwdata[6:5];
        git[3:0] <= git[3:0] & ~hwdata[3:0];
        if (bx_clr_ok) git[4] <= git[4] & ~hwdata[4];
      end
      // set once the whole set has received
      if (bx_rise) begin
        git[4]  <= 1'b1;
        bx_snap <= fb_set;
      end
      if (ovr_evt) git[5] <= 1'b1;
      if (bus_off_status_evt) git[6] <= 1'b1;
      if (gen_err && (|err_v)) git[3:0] <= git[3:0] | err_v[3:0];
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      sit[s] = (sl[s].sta[0] & ie[0]) | (sl[s].sta[1] & ie[1]) |
               ((|sl[s].sta[6:2]) & ie[2]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hpri <= HPRI_NONE;
    end else if (ce) begin
      // lowest enabled pending slot, page coded
      hpri <= HPRI_NONE;
      for (int s = NS - 1; s >= 0; s--) if (sit[s]) hpri <= 4'(s);
    end
  end

  // ****************************************************
  // Timer
  // ****************************************************
  logic [2:0] div8;
  logic [7:0] psc;
  logic       tick;
  logic       controller_enabled_flag_q;

  // tick from divided clock and prescaler
  assign tick    = controller_enabled_flag & (div8 == DIV_LAST) & (psc == tcon);
  assign ovr_evt = ce & tick & (timer == TIMER_MAX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      controller_enabled_flag       <= 1'b0;
      controller_enabled_flag_q     <= 1'b0;
      div8       <= 3'h0;
      psc        <= 8'h00;
      timer      <= TIMER_RST;
      sync_stamp <= TIMER_RST;
    end else if (ce) begin
      controller_enabled_flag   <= gcon[0] & !swres;
      controller_enabled_flag_q <= controller_enabled_flag;
      if (!controller_enabled_flag || (controller_enabled_flag && !controller_enabled_flag_q)) begin
        div8  <= 3'h0;
        psc   <= 8'h00;
        timer <= TIMER_RST;
      end else begin
        div8 <= div8 + 3'h1;
        if (div8 == DIV_LAST) psc <= (psc == tcon) ? 8'h00 : psc + 8'h01;
        if (tick) timer <= timer + 16'h0001;
      end
      // sync point chosen by select bit
      if (gcon[1] && (gcon[2] ? fr.eof : fr.sof)) sync_stamp <= timer;
    end
  end

  // ****************************************************
  // Error detection
  // ****************************************************
  logic [2:0]  run;
  logic        last_rx;
  logic [14:0] crc;
  logic [14:0] crc_rx;
  logic        e_bit;
  logic        e_stuff;
  logic        e_crc;
  logic        e_form;
  logic        e_ack;

  // monitored differs from sent, with exceptions
  assign e_bit = bt.strobe & bt.sending & (bt.tx != bt.rx) &
                 !(bt.tx & !bt.rx & (bt.arb | bt.ack_slot)) &
                 !(bt.err_frame & !bt.rx);
  // a sixth equal bit is an error
  assign e_stuff = bt.strobe & bt.stuffed & (bt.rx == last_rx) &
                   (run == STUFF_LIMIT);
  assign e_crc  = bt.strobe & bt.crc_end & !bt.sending &
                  ({crc_rx[13:0], bt.rx} != crc);
  // dominant in fixed-form bits, missing ack
  assign e_form = bt.strobe & bt.fixed_form & !bt.rx;
  assign e_ack  = bt.strobe & bt.sending & bt.ack_slot & bt.rx;
  assign err_v  = ce ? {e_bit, e_stuff, e_crc, e_form, e_ack} : 5'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run     <= 3'h0;
      last_rx <= 1'b1;
      crc     <= 15'h0;
      crc_rx  <= 15'h0;
    end else if (ce && bt.strobe) begin
      last_rx <= bt.rx;
      if (!bt.stuffed || bt.rx != last_rx) run <= 3'h1;
      else if (run != STUFF_LIMIT) run <= run + 3'h1;
      if (fr.sof) crc <= 15'h0;
      else if (bt.crc_cover)
        crc <= {crc[13:0], 1'b0} ^ ((bt.rx ^ crc[14]) ? CRC_POLY : 15'h0);
      if (bt.crc_field) crc_rx <= {crc_rx[13:0], bt.rx};
    end
  end

  // ****************************************************
  // Fault confinement
  // ****************************************************
  logic [3:0] susp;
  logic       any_err;

  assign any_err     = |err_v;
  assign err_passive = (tec > PASSIVE_LIM) | ({1'b0, rec} > PASSIVE_LIM);
  assign bus_off_status_evt    = ce & !bus_off_status & (tec > BUSOFF_LIM);
  assign drive_en    = controller_enabled_flag & !bus_off_status;
  assign tx_hold     = (susp != 4'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tec           <= 9'h0;
      rec           <= 8'h0;
      bus_off_status          <= 1'b0;
      susp          <= 4'h0;
      err_frame_req <= 1'b0;
    end else if (ce) begin
      // error frame after own or foreign error
      err_frame_req <= (any_err | fr.foreign_err) & !bus_off_status;
      if (swres) begin
        tec  <= 9'h0;
        rec  <= 8'h0;
        bus_off_status <= 1'b0;
      end else if (!bus_off_status) begin
        if (any_err && bt.sending)
          tec <= (tec > 9'h1ff - TEC_STEP) ? 9'h1ff : tec + TEC_STEP;
        else if (fr.tx_done && tec != 9'h0) tec <= tec - 9'h1;
        if (any_err && !bt.sending && rec != 8'hff) rec <= rec + 8'h1;
        else if (fr.rx_done && rec != 8'h0) rec <= rec - 8'h1;
        if (bus_off_status_evt) bus_off_status <= 1'b1;
      end
      if (fr.tx_done && err_passive) susp <= SUSPEND_BITS;
      else if (bt.strobe && susp != 4'h0) susp <= susp - 4'h1;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_enable_rise;
    ce && gcon[0] && !controller_enabled_flag ##1 ce && controller_enabled_flag;
  endsequence

  a_timer_start: assert property (s_enable_rise |=> timer == TIMER_RST)
    else $error("timer did not start at zero");
  a_overrun_set: assert property (ovr_evt |=> git[5] && timer == 16'h0)
    else $error("overrun flag missing on wrap");
  a_index_wrap: assert property (ce && rd_msg && !auto_increment_disable_dis && idx == 3'h7
    && !(we && wr_addr == OFS_PAGE) |=> idx == 3'h0)
    else $error("index did not wrap to zero");
  a_busoff_quiet: assert property (bus_off_status |-> !drive_en)
    else $error("bus-off node still drives");
  a_passive_lim: assert property (tec > 9'd127 |-> err_passive)
    else $error("passive not reported above threshold");
  a_buffer_complete_flag_guard: assert property (ce && git[4] && !bx_clr_ok && !swres
    |=> git[4])
    else $error("buffer-complete cleared too early");
  a_stuff_sixth: assert property (ce && e_stuff && !bus_off_status
    |=> err_frame_req)
    else $error("stuff error without error frame");
  a_reply_turn: assert property (ce && fr.id_strobe && controller_enabled_flag && hit_any
    && fr.rtr && sl[hit_idx].reply_valid_bit |=> reply_req
    && !sl[reply_slot].reply_valid_bit && sl[reply_slot].mode == MODE_TX)
    else $error("auto reply not set up");
  a_hit_lowest: assert property (hit_any |-> !(sl[0].mode[1]
    && hit_idx != 3'h0 && sl[0].identifier_mask == 29'h0 && !sl[0].rtr_m
    && !sl[0].ide_m && fr.rb == sl[0].rb))
    else $error("lower matching slot skipped");
  a_tick_gate: assert property (!controller_enabled_flag |-> !tick)
    else $error("timer ticked while disabled");
endmodule : cmft_core

// [sim/cmft_node.sv]
`timescale 1ns/10ps
module cmft_node import cmft_pkg::*; (
  input  wire logic  clk,
  output cmft_frame_s fr,
  output cmft_bit_s   bt
);
  // ****
  // Far-side frame and bit source
  // ****
  initial fr = '0;
  initial bt = '0;
  task automatic put(input cmft_frame_s f);
    @(posedge clk);
    fr <= f;
    @(posedge clk);
    fr <= '{id: ~f.id, data: ~f.data, default: '0};
  endtask : put
  task automatic send(input logic [28:0] id, input logic [63:0] pl);
    put('{sof: 1'b1, default: '0});
    put('{id_strobe: 1'b1, id: id, dlc: 4'h8, default: '0});
    for (int i = 0; i < 8; i++) begin
      put('{byte_strobe: 1'b1, data: pl[8*i+:8], default: '0});
    end
    put('{rx_done: 1'b1, default: '0});
  endtask : send
  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(posedge clk);
      bt <= '{strobe: 1'b1, rx: b, tx: b, stuffed: 1'b1, default: '0};
      @(posedge clk);
      bt <= '{rx: ~b, tx: ~b, default: '0};
    end
  endtask : bits
endmodule : cmft_node

// [sim/tb_top.sv]
`timescale 1ns/10ps
module tb_top import cmft_pkg::*; ;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } cmft_row_s;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, efr, den, sshot;
  logic        ce     = 1'b1;
  logic [2:0]  rslot;
  logic [31:0] hrdata, v;
  cmft_frame_s fr;
  cmft_bit_s   bt;
  int          error_cnt = 0, n_compared = 0, cyc = 0, n_efr = 0;
  cmft_row_s   rows [9] = '{
    '{OFS_GSTA, 1'b0, 32'h0, 32'h0},
    '{OFS_TIMER, 1'b0, 32'h0, 32'h0},
    '{OFS_HPRI, 1'b0, 32'h0, 32'hf},
    '{OFS_ECNT, 1'b0, 32'h0, 32'h0},
    '{OFS_GIT, 1'b0, 32'h0, 32'h0},
    '{8'h44, 1'b1, 32'h5, 32'h0},
    '{OFS_TCON, 1'b1, 32'h3, 32'h3},
    '{OFS_PAGE, 1'b1, 32'h6, 32'h6},
    '{OFS_SSTA, 1'b0, 32'h0, 32'h0}};
  always #12.5 clk = ~clk;
  cmft_node node (.clk(clk), .fr(fr), .bt(bt));
  cmft_core DUT (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bt(bt), .fr(fr),
    .err_frame_req(efr), .err_passive(), .drive_en(den), .tx_hold(),
    .single_shot(sshot), .reply_req(), .reply_slot(rslot));
  // ****
  // Bus tasks and report
  // ****
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(v, e);
  endtask : rd
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (efr === 1'b1) n_efr++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) xfer(rows[i].a, 1'b1, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    xfer(OFS_IE, 1'b1, 32'h1);
    for (int p = 0; p < 2; p++) begin
      xfer(OFS_PAGE, 1'b1, p);
      xfer(OFS_SCFG, 1'b1, 32'h2);
      xfer(OFS_SIDT, 1'b1, 32'h317);
      xfer(OFS_SMSK, 1'b1, 32'h7fffffff);
    end
    xfer(OFS_GCON, 1'b1, 32'h1);
    rd(OFS_GSTA, 32'h4);
    chk(den, 1'b1);
    node.send(29'h317, 64'h1716151413121110);
    xfer(OFS_PAGE, 1'b1, 32'h0);
    rd(OFS_SSTA, 32'h1);
    rd(OFS_SCFG, 32'h802);
    rd(OFS_SIDT, 32'h317);
    rd(OFS_HPRI, 32'h0);
    for (int i = 0; i < 9; i++) rd(OFS_SMSG, 32'h10 + i % 8);
    xfer(OFS_PAGE, 1'b1, 32'h1);
    rd(OFS_SSTA, 32'h0);
    node.put('{sof: 1'b1, default: '0});
    node.bits(5, 1'b0);
    node.bits(1, 1'b1);
    rd(OFS_GIT, 32'h0);
    chk(n_efr, 32'h0);
    node.bits(6, 1'b0);
    rd(OFS_GIT, 32'h8);
    chk(n_efr, 32'h1);
    rd(OFS_ECNT, 32'h1);
    xfer(OFS_GIT, 1'b1, 32'h8);
    rd(OFS_GIT, 32'h0);
    xfer(OFS_GCON, 1'b1, 32'h3);
    xfer(OFS_PAGE, 1'b1, 32'h2);
    xfer(OFS_SCFG, 1'b1, 32'h16);
    xfer(OFS_SIDT, 1'b1, 32'h123);
    xfer(OFS_SMSK, 1'b1, 32'h7fffffff);
    node.put('{id_strobe: 1'b1, id: 29'h123, rtr: 1'b1, dlc: 4'h3,
               default: '0});
    rd(OFS_SCFG, 32'h301);
    rd(OFS_SSTA, 32'h0);
    chk(rslot, 32'h2);
    chk(sshot, 1'b1);
    ce <= 1'b0;
    xfer(OFS_TCON, 1'b1, 32'h9);
    ce <= 1'b1;
    rd(OFS_TCON, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_ECNT, 32'h0);
    rd(OFS_SCFG, 32'h0);
    chk(den, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
